// file: verilog/ifeb_top.sv
// Interrupt flag groups 3/4, enable groups 0-2, event status.
// Assumes sources and the other flag/enable banks run on CLK.
`timescale 1ns/1ps
`include "ifeb_defs.svh"
module ifeb_top
    import ifeb_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [15:0] SRC_G3,
    input wire logic [15:0] SRC_G4,
    input wire logic [15:0] FLAGS_G0,
    input wire logic [15:0] FLAGS_G1,
    input wire logic [15:0] FLAGS_G2,
    input wire logic [15:0] EN_G3,
    input wire logic [15:0] EN_G4,
    output logic [15:0] PEND_G0,
    output logic [15:0] PEND_G1,
    output logic [15:0] PEND_G2,
    output logic [15:0] PEND_G3,
    output logic [15:0] PEND_G4,
    output logic [2:0] T1_PRIORITY,
    output logic IRQ
);
    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    ifeb_reg_if bus();

    ifeb_avmm u_avmm (
        .clk(CLK),
        .reset(RESET),
        .address(AVS_ADDRESS),
        .read(AVS_READ),
        .write(AVS_WRITE),
        .writedata(AVS_WRITEDATA),
        .byteenable(AVS_BYTEENABLE),
        .readdata(AVS_READDATA),
        .waitrequest(AVS_WAITREQUEST),
        .bus(bus.slave)
    );

    ifeb_reg_t sel;
    ifeb_word_t lane_mask;
    ifeb_word_t wdata16;
    logic [2:0] en_wr;

    assign lane_mask = {{8{bus.be[1]}}, {8{bus.be[0]}}};
    assign wdata16 = bus.wdata[15:0];

    always_comb begin
        if (bus.addr == `IFEB_OFS_FLAGS3) begin
            sel = REG_FLAGS3;
        end else if (bus.addr == `IFEB_OFS_FLAGS4) begin
            sel = REG_FLAGS4;
        end else if (bus.addr == `IFEB_OFS_EN0) begin
            sel = REG_EN0;
        end else if (bus.addr == `IFEB_OFS_EN1) begin
            sel = REG_EN1;
        end else if (bus.addr == `IFEB_OFS_EN2) begin
            sel = REG_EN2;
        end else if (bus.addr == `IFEB_OFS_PRIO) begin
            sel = REG_PRIO;
        end else if (bus.addr == `IFEB_OFS_EVT) begin
            sel = REG_EVT;
        end else if (bus.addr == `IFEB_OFS_EVTMASK) begin
            sel = REG_EVTMASK;
        end else begin
            sel = REG_NONE;
        end
    end

    assign en_wr[0] = bus.wr && sel == REG_EN0;
    assign en_wr[1] = bus.wr && sel == REG_EN1;
    assign en_wr[2] = bus.wr && sel == REG_EN2;

    // ------------------------------------------------------------
    // Flag groups 3 and 4
    // ------------------------------------------------------------
    ifeb_word_t flags3;
    ifeb_word_t flags4;
    ifeb_word_t f3_wmask;
    ifeb_word_t f4_wmask;

    // Set by source wins over a software write in the same cycle
    assign f3_wmask = (bus.wr && sel == REG_FLAGS3) ? lane_mask
        : 16'h0000;
    assign f4_wmask = (bus.wr && sel == REG_FLAGS4) ? lane_mask
        : 16'h0000;

    ifeb_flag_bank #(
        .WIDTH(16),
        .MASK(`IFEB_MASK_FLAGS3) // R5
    ) u_flags3 (
        .clk(CLK),
        .reset(RESET),
        .set(SRC_G3),
        .wr_mask(f3_wmask),
        .wdata(wdata16),
        .q(flags3)
    );

    ifeb_flag_bank #(
        .WIDTH(16),
        .MASK(`IFEB_MASK_FLAGS4) // R6
    ) u_flags4 (
        .clk(CLK),
        .reset(RESET),
        .set(SRC_G4),
        .wr_mask(f4_wmask),
        .wdata(wdata16),
        .q(flags4)
    );

    // ------------------------------------------------------------
    // Enable groups 0 to 2
    // ------------------------------------------------------------
    localparam ifeb_word_t EN_MASK [3] = '{
        `IFEB_MASK_EN0, // R7 R8
        `IFEB_MASK_EN1, // R9 R10
        `IFEB_MASK_EN2 // R11 R12 R14
    };
    ifeb_word_t en [3];

    for (genvar g = 0; g < 3; g++) begin : g_en
        always_ff @(posedge CLK) begin
            if (RESET) begin
                en[g] <= `IFEB_RST_WORD; // R4
            end else if (en_wr[g]) begin
                // Only implemented bits can ever become one
                en[g] <= (en[g] & ~lane_mask) |
                    (wdata16 & lane_mask & EN_MASK[g]); // R2 R3
            end
        end
    end

    // ------------------------------------------------------------
    // Timer1 priority field
    // ------------------------------------------------------------
    logic [2:0] t1_prio;
    ifeb_word_t t1_gate;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            t1_prio <= `IFEB_RST_PRIO;
        end else if (bus.wr && sel == REG_PRIO && bus.be[0]) begin
            t1_prio <= bus.wdata[2:0];
        end
    end

    // Priority zero removes timer1 from arbitration entirely
    assign t1_gate = (t1_prio == `IFEB_PRIO_OFF) ? `IFEB_T1_CUT
        : 16'hFFFF; // R13

    always_ff @(posedge CLK) begin
        if (RESET) begin
            T1_PRIORITY <= `IFEB_RST_PRIO;
        end else begin
            T1_PRIORITY <= t1_prio; // R13
        end
    end

    // ------------------------------------------------------------
    // Pending requests
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PEND_G0 <= `IFEB_RST_WORD;
            PEND_G1 <= `IFEB_RST_WORD;
            PEND_G2 <= `IFEB_RST_WORD;
            PEND_G3 <= `IFEB_RST_WORD;
            PEND_G4 <= `IFEB_RST_WORD;
        end else begin
            PEND_G0 <= FLAGS_G0 & en[0] & t1_gate; // R15
            PEND_G1 <= FLAGS_G1 & en[1]; // R15
            PEND_G2 <= FLAGS_G2 & en[2]; // R15
            PEND_G3 <= flags3 & EN_G3; // R15
            PEND_G4 <= flags4 & EN_G4; // R15
        end
    end

    // ------------------------------------------------------------
    // Event status, mask and interrupt line
    // ------------------------------------------------------------
    logic [`IFEB_EVT_W-1:0] evt_status;
    logic [`IFEB_EVT_W-1:0] evt_mask;
    logic [`IFEB_EVT_W-1:0] evt_set;
    logic [`IFEB_EVT_W-1:0] next_evt;

    assign evt_set[0] = |(SRC_G3 & `IFEB_MASK_FLAGS3 & ~flags3);
    assign evt_set[1] = |(SRC_G4 & `IFEB_MASK_FLAGS4 & ~flags4);
    assign evt_set[2] = (bus.wr || bus.rd) && sel == REG_NONE;

    always_comb begin
        next_evt = evt_status;
        if (bus.wr && sel == REG_EVT && bus.be[0]) begin
            next_evt = evt_status & ~bus.wdata[`IFEB_EVT_W-1:0];
        end
        // New events beat a clear in the same cycle
        next_evt = next_evt | evt_set;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            evt_status <= '0;
        end else begin
            evt_status <= next_evt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            evt_mask <= '0;
        end else if (bus.wr && sel == REG_EVTMASK && bus.be[0]) begin
            evt_mask <= bus.wdata[`IFEB_EVT_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(evt_status & evt_mask);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        bus.rdata = 32'h0000_0000;
        case (sel)
            REG_FLAGS3: bus.rdata[15:0] = flags3; // R1
            REG_FLAGS4: bus.rdata[15:0] = flags4; // R1
            REG_EN0: bus.rdata[15:0] = en[0]; // R2
            REG_EN1: bus.rdata[15:0] = en[1]; // R2
            REG_EN2: bus.rdata[15:0] = en[2]; // R2
            REG_PRIO: bus.rdata[2:0] = t1_prio;
            REG_EVT: bus.rdata[`IFEB_EVT_W-1:0] = evt_status;
            REG_EVTMASK: bus.rdata[`IFEB_EVT_W-1:0] = evt_mask;
            default: bus.rdata = 32'h0000_0000; // R3
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    chk_reset_clear: assert property (disable iff (1'b0)
        RESET |=> en[0] == 16'h0000 && en[1] == 16'h0000 &&
        en[2] == 16'h0000 && flags3 == 16'h0000 &&
        flags4 == 16'h0000) // R4
        else $error("bank not cleared by reset");

    chk_reset_pend: assert property (disable iff (1'b0)
        RESET |=> PEND_G0 == 16'h0000 && PEND_G3 == 16'h0000 &&
        !IRQ) // R4
        else $error("pending or irq set after reset");

    chk_en2_layout: assert property (
        en_wr[2] && wdata16 == 16'hFFFF && bus.be == 4'hF
        |=> en[2] == 16'hDFFF) // R11 R12 R14
        else $error("enable group 2 layout wrong");

    chk_en1_layout: assert property (
        en_wr[1] && wdata16 == 16'hFFFF && bus.be == 4'hF
        |=> en[1] == 16'hFFFB) // R9 R10
        else $error("enable group 1 layout wrong");

    chk_en0_layout: assert property (
        en_wr[0] && wdata16 == 16'hFFFF && bus.be == 4'hF
        |=> en[0] == 16'h7FFF) // R7 R8
        else $error("enable group 0 layout wrong");

    chk_f3_layout: assert property (
        SRC_G3 == 16'hFFFF |=> flags3 == 16'h21FF) // R5
        else $error("flag group 3 layout wrong");

    chk_f4_layout: assert property (
        SRC_G4 == 16'hFFFF |=> flags4 == 16'h00F6) // R6
        else $error("flag group 4 layout wrong");

    chk_en_block: assert property (
        (en[1] == 16'h0000) [*2] |-> PEND_G1 == 16'h0000) // R2
        else $error("disabled source reached pending");

    chk_pend_and: assert property (
        PEND_G3 != 16'h0000 |->
        ($past(flags3) & $past(EN_G3)) == PEND_G3) // R15
        else $error("pending without flag and enable");

    chk_flag_clear: assert property (
        bus.wr && sel == REG_FLAGS3 && bus.be == 4'hF &&
        wdata16 == 16'h0000 && SRC_G3 == 16'h0000
        |=> flags3 == 16'h0000 ##1 PEND_G3 == 16'h0000) // R15
        else $error("flag not cleared by zero write");

    chk_prio_off: assert property (
        (t1_prio == 3'h0) [*2] |-> !PEND_G0[`IFEB_T1_BIT]) // R13
        else $error("timer1 pending at priority zero");

    chk_irq_level: assert property (
        |(evt_status & evt_mask) |=> IRQ)
        else $error("irq low while unmasked status set");

    chk_evt_keep: assert property (
        evt_set[0] |=> evt_status[0])
        else $error("event lost against clear");

    chk_unmapped_zero: assert property (
        AVS_READ && !AVS_WAITREQUEST && $past(sel) == REG_NONE &&
        $past(AVS_READ) |-> AVS_READDATA == 32'h0000_0000) // R3
        else $error("unmapped read not zero");

    cov_flag_pend: cover property (
        SRC_G3[13] ##1 EN_G3[13] ##1 PEND_G3[13]);

    cov_set_clear: cover property (
        SRC_G4[1] && bus.wr && sel == REG_FLAGS4);

    cov_irq: cover property (
        !IRQ ##1 IRQ ##[1:20] !IRQ);

    cov_prio_off: cover property (
        t1_prio == 3'h0 && FLAGS_G0[`IFEB_T1_BIT] && en[0][3]);
endmodule

// file: verilog/ifeb_defs.svh
// Offsets, field masks, reset values of the flag/enable bank.
// Assumes a 32-bit word-aligned Avalon-MM register port.
// Contract
// (R1) Flag bit reads 1 once its source requested; software may read/write.
// (R2) Enable bit 1 lets its source request through; 0 blocks it.
// (R3) Unimplemented bits ignore writes and read as zero.
// (R4) Reset clears every flag and enable bit.
// (R5) Flag group 3 holds bits 13, 8 and 7..0.
// (R6) Flag group 4 holds bits 7..4, 2 and 1.
// (R7) Enable group 0 upper byte: bits 14..8 implemented, bit 15 not.
// (R8) Enable group 0 lower byte: all eight bits implemented.
// (R9) Enable group 1 upper byte: all eight bits implemented.
// (R10) Enable group 1 lower byte: bit 2 unimplemented, others implemented.
// (R11) Enable group 2 upper byte: bit 13 unimplemented, others implemented.
// (R12) Enable group 2 bits 7..3 implemented.
// (R13) Priority 7 highest, 1 lowest; 0 disables the source.
// (R14) Enable group 2 bits 2..0 implemented.
// (R15) Request pending only while flag and enable both set.
`ifndef IFEB_DEFS_SVH
`define IFEB_DEFS_SVH
`define IFEB_OFS_FLAGS3 8'h00
`define IFEB_OFS_FLAGS4 8'h04
`define IFEB_OFS_EN0 8'h08
`define IFEB_OFS_EN1 8'h0C
`define IFEB_OFS_EN2 8'h10
`define IFEB_OFS_PRIO 8'h14
`define IFEB_OFS_EVT 8'h18
`define IFEB_OFS_EVTMASK 8'h1C
`define IFEB_MASK_FLAGS3 16'h21FF
`define IFEB_MASK_FLAGS4 16'h00F6
`define IFEB_MASK_EN0 16'h7FFF
`define IFEB_MASK_EN1 16'hFFFB
`define IFEB_MASK_EN2 16'hDFFF
`define IFEB_RST_WORD 16'h0000
`define IFEB_RST_PRIO 3'h4
`define IFEB_PRIO_OFF 3'h0
`define IFEB_T1_BIT 3
`define IFEB_T1_CUT 16'hFFF7
`define IFEB_EVT_W 3
`endif

// file: verilog/ifeb_pkg.sv
// Types shared by the flag/enable bank modules.
// Assumes the constants header is compiled alongside.
package ifeb_pkg;
    typedef logic [15:0] ifeb_word_t;
    typedef enum logic [3:0] {
        REG_FLAGS3, REG_FLAGS4, REG_EN0, REG_EN1, REG_EN2,
        REG_PRIO, REG_EVT, REG_EVTMASK, REG_NONE
    } ifeb_reg_t;
    typedef enum logic {BUS_IDLE, BUS_ACK} ifeb_bus_st_t;
endpackage

// file: verilog/ifeb_reg_if.sv
// Decoded register access between bus slave and register file.
// Assumes one clock; strobes last one cycle.
`timescale 1ns/1ps
interface ifeb_reg_if;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    modport slave(output addr, output wdata, output be, output wr,
        output rd, input rdata);
    modport regs(input addr, input wdata, input be, input wr,
        input rd, output rdata);
endinterface

// file: verilog/ifeb_avmm.sv
// Avalon-MM slave front end with one wait state per access.
// Assumes master holds request until waitrequest is seen low.
`timescale 1ns/1ps
module ifeb_avmm
    import ifeb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    ifeb_reg_if.slave bus
);
    ifeb_bus_st_t st;

    assign bus.addr = address;
    assign bus.wdata = writedata;
    assign bus.be = byteenable;
    // Register effects happen only at the completing edge
    assign bus.wr = write && st == BUS_ACK;
    assign bus.rd = read && st == BUS_ACK;

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= BUS_IDLE;
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else begin
            case (st)
                BUS_IDLE: begin
                    if (read || write) begin
                        st <= BUS_ACK;
                        waitrequest <= 1'b0;
                        readdata <= read ? bus.rdata : 32'h0000_0000;
                    end
                end
                default: begin
                    st <= BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    chk_wait_one: assert property (@(posedge clk) disable iff (reset)
        (read || write) && st == BUS_IDLE |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest not low for exactly one cycle");
endmodule

// file: verilog/ifeb_flag_bank.sv
// One 16-bit flag register: sources set, software writes.
// Assumes set inputs are on the same clock as the bank.
`timescale 1ns/1ps
module ifeb_flag_bank
    import ifeb_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter logic [15:0] MASK = 16'h0000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] wr_mask,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] q
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        if (MASK[i]) begin : g_impl
            always_ff @(posedge clk) begin
                if (reset) begin
                    q[i] <= 1'b0; // R4
                end else if (set[i]) begin
                    q[i] <= 1'b1; // R1
                end else if (wr_mask[i]) begin
                    q[i] <= wdata[i]; // R1
                end
            end
        end else begin : g_none
            assign q[i] = 1'b0; // R3
        end
    end

    chk_set_wins: assert property (@(posedge clk) disable iff (reset)
        (|(set & MASK[WIDTH-1:0])) |=> ((q & $past(set)) ==
        ($past(set) & MASK[WIDTH-1:0]))) // R1
        else $error("flag source lost against a write");
    chk_unimpl_flag: assert property (@(posedge clk) disable iff (reset)
        (q & ~MASK[WIDTH-1:0]) == '0) // R3
        else $error("unimplemented flag bit reads one");
endmodule

// file: testbench/ifeb_src_model.sv
// Peripheral source model: turns bench requests into one-cycle set pulses.
// Assumes the bench raises go bits for one cycle, after a rising edge.
`timescale 1ns/1ps
module ifeb_src_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] go_g3,
    input wire logic [15:0] go_g4,
    output logic [15:0] src_g3,
    output logic [15:0] src_g4
);
    // Registered, so a request always lands one edge late like a peripheral
    always_ff @(posedge clk) begin
        if (reset) begin
            src_g3 <= 16'h0000;
            src_g4 <= 16'h0000;
        end else begin
            src_g3 <= go_g3;
            src_g4 <= go_g4;
        end
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the interrupt flag/enable bank.
// Assumes the design top, its header and the source model are compiled.
`timescale 1ns/1ps
`include "ifeb_defs.svh"
module tb_top;
    logic CLK, RESET;
    logic [7:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, irq;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [15:0] flags_g0, flags_g1, flags_g2, en_g3, en_g4;
    logic [15:0] go_g3, go_g4, src_g3, src_g4;
    logic [15:0] pend [5];
    logic [15:0] f [5];
    logic [15:0] e [5];
    logic [2:0] t1_priority;
    logic [7:0] offs [6];
    int n_mismatch, check_count;

    assign offs = '{`IFEB_OFS_FLAGS3, `IFEB_OFS_FLAGS4, `IFEB_OFS_EN0,
        `IFEB_OFS_EN1, `IFEB_OFS_EN2, `IFEB_OFS_PRIO};

    ifeb_top i_dut (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .SRC_G3(src_g3), .SRC_G4(src_g4), .FLAGS_G0(flags_g0),
        .FLAGS_G1(flags_g1), .FLAGS_G2(flags_g2), .EN_G3(en_g3),
        .EN_G4(en_g4), .PEND_G0(pend[0]), .PEND_G1(pend[1]),
        .PEND_G2(pend[2]), .PEND_G3(pend[3]), .PEND_G4(pend[4]),
        .T1_PRIORITY(t1_priority), .IRQ(irq));

    ifeb_src_model i_src (.clk(CLK), .reset(RESET), .go_g3(go_g3),
        .go_g4(go_g4), .src_g3(src_g3), .src_g4(src_g4));

    always #5 CLK = ~CLK;

    // ----------------------------------------
    // Expectations and checking
    // ----------------------------------------
    function automatic logic [15:0] imp_mask(input logic [7:0] a);
        case (a)
            `IFEB_OFS_FLAGS3: return 16'h21FF;
            `IFEB_OFS_FLAGS4: return 16'h00F6;
            `IFEB_OFS_EN0: return 16'h7FFF;
            `IFEB_OFS_EN1: return 16'hFFFB;
            `IFEB_OFS_EN2: return 16'hDFFF;
            `IFEB_OFS_PRIO: return 16'h0007;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Avalon-MM master
    // ----------------------------------------
    // Request held until waitrequest is seen low at a rising edge
    // No cycle count assumed; only the watchdog ends a hung access
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge CLK);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge CLK);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic pulse(input logic [15:0] a, input logic [15:0] b);
        @(posedge CLK);
        go_g3 <= a;
        go_g4 <= b;
        @(posedge CLK);
        go_g3 <= 16'h0000;
        go_g4 <= 16'h0000;
        repeat (3) @(posedge CLK);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        RESET = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        {flags_g0, flags_g1, flags_g2, en_g3, en_g4, go_g3, go_g4} = '0;
        n_mismatch = 0;
        check_count = 0;
        void'($urandom(32'hF895BFD8));
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        check(32'(t1_priority), 32'h4);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, offs[i], 32'h0, q);
            check(q, (i == 5) ? 32'h4 : 32'h0);
        end
        // All-ones first, then random patterns, over the flag, enable and priority registers
        for (int i = 0; i < 36; i++) begin
            f[0] = (i < 6) ? 16'hFFFF : 16'($urandom);
            wr(offs[i % 6], {16'hFFFF, f[0]});
            bus(1'b0, offs[i % 6], 32'h0, q);
            check(q, {16'h0, f[0] & imp_mask(offs[i % 6])});
        end
        bus(1'b0, 8'h40, 32'h0, q);
        check(q, 32'h0);
        bus(1'b0, `IFEB_OFS_EVT, 32'h0, q);
        check(q, 32'h4);
        wr(`IFEB_OFS_EVT, 32'h7);
        wr(`IFEB_OFS_FLAGS3, 32'h0);
        wr(`IFEB_OFS_FLAGS4, 32'h0);
        wr(`IFEB_OFS_EVTMASK, 32'h1);
        bus(1'b0, `IFEB_OFS_EVTMASK, 32'h0, q);
        check(q, 32'h1);
        // Every source fires, implemented or not
        pulse(16'hFFFF, 16'hFFFF);
        check(32'(irq), 32'h1);
        bus(1'b0, `IFEB_OFS_FLAGS3, 32'h0, q);
        check(q, 32'h21FF);
        bus(1'b0, `IFEB_OFS_FLAGS4, 32'h0, q);
        check(q, 32'h00F6);
        wr(`IFEB_OFS_EVT, 32'h1);
        repeat (2) @(posedge CLK);
        check(32'(irq), 32'h0);
        bus(1'b0, `IFEB_OFS_EVT, 32'h0, q);
        check(q, 32'h2);
        wr(`IFEB_OFS_FLAGS3, 32'h0);
        bus(1'b0, `IFEB_OFS_FLAGS3, 32'h0, q);
        check(q, 32'h0);
        // Source set lands on the same edge as a clearing write
        fork
            wr(`IFEB_OFS_FLAGS4, 32'h0);
            pulse(16'h0000, 16'h0002);
        join
        bus(1'b0, `IFEB_OFS_FLAGS4, 32'h0, q);
        check(q, 32'h2);
        wr(`IFEB_OFS_PRIO, 32'h7);
        // Pending outputs against random flags and enables
        for (int i = 0; i < 12; i++) begin
            for (int k = 0; k < 5; k++) begin
                f[k] = 16'($urandom);
                e[k] = 16'($urandom);
            end
            flags_g0 <= f[0];
            flags_g1 <= f[1];
            flags_g2 <= f[2];
            en_g3 <= e[3];
            en_g4 <= e[4];
            wr(`IFEB_OFS_FLAGS3, {16'h0, f[3]});
            wr(`IFEB_OFS_FLAGS4, {16'h0, f[4]});
            for (int k = 0; k < 3; k++) begin
                wr(offs[k + 2], {16'h0, e[k]});
            end
            repeat (3) @(posedge CLK);
            for (int k = 0; k < 5; k++) begin
                check(32'(pend[k]), 32'(f[k] & e[k] &
                    imp_mask(k < 3 ? offs[k + 2] : offs[k - 3])));
            end
        end
        // Priority zero silences timer1 even when flagged and enabled
        flags_g0 <= 16'h0008;
        wr(`IFEB_OFS_EN0, 32'h8);
        wr(`IFEB_OFS_PRIO, 32'h0);
        repeat (3) @(posedge CLK);
        check(32'(pend[0]), 32'h0);
        wr(`IFEB_OFS_PRIO, 32'h1);
        repeat (3) @(posedge CLK);
        check(32'(pend[0]), 32'h8);
        check(32'(t1_priority), 32'h1);
        // Lane 0 only: upper byte of enable group 1 keeps its zeros
        wr(`IFEB_OFS_EN1, 32'h0);
        avs_byteenable <= 4'h1;
        wr(`IFEB_OFS_EN1, 32'hFFFF);
        avs_byteenable <= 4'hF;
        bus(1'b0, `IFEB_OFS_EN1, 32'h0, q);
        check(q, 32'h00FB);
        summarize();
    end

    // Whole run is a few hundred cycles; this is ample
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
endmodule
